// ===== logic/lsed_pkg.sv
// constants shared by the serial error detection block
package lsed_pkg;
    localparam int NFLAG = 9;
    localparam int F_PE = 0;
    localparam int F_OE = 1;
    localparam int F_FE = 2;
    localparam int F_PBE = 3;
    localparam int F_NRE = 4;
    localparam int F_BE = 5;
    localparam int F_CE = 6;
    localparam int F_ISF = 7;
    localparam int F_BRK = 8;
    localparam int GCR1_PAR_BIT = 2;
    localparam int RXST_BRK_BIT = 5;
    localparam int DIV_W = 16;
    localparam int FRM_W = 10;
    localparam int VEC_W = 4;
    localparam logic [3:0] BRK_BITS = 4'hA;
    localparam logic [3:0] VEC_NONE = 4'h0;
    localparam logic [7:0] CHK_GOOD = 8'hFF;
    localparam logic [8:0] FLAGS_RST = 9'h000;
    localparam logic [7:0] RXST_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

// ===== logic/lsed_core_if.sv
// signals between the top and its divider and checksum units
interface lsed_core_if;
    logic [lsed_pkg::DIV_W-1:0] div_value;
    logic bit_tick;
    logic chk_byte_valid;
    logic [7:0] chk_byte;
    logic chk_is_pid;
    logic chk_is_last;
    logic chk_enhanced;
    logic chk_err;
    modport top_mp (output div_value, chk_byte_valid, chk_byte, chk_is_pid, chk_is_last, chk_enhanced,
                    input bit_tick, chk_err);
    modport div_mp (input div_value, output bit_tick);
    modport chk_mp (input chk_byte_valid, chk_byte, chk_is_pid, chk_is_last, chk_enhanced, output chk_err);
endinterface

// ===== logic/lsed_bit_div.sv
// bit period divider: one-cycle tick every div_value+1 clocks
module lsed_bit_div
(
    input wire logic core_clk,
    input wire logic nrst,
    lsed_core_if.div_mp cif
);
    logic [lsed_pkg::DIV_W-1:0] cnt_ff;
    logic tick_ff;
    wire cnt_zero = (cnt_ff == '0);
    wire [lsed_pkg::DIV_W-1:0] nxt_cnt = cnt_zero ? cif.div_value : cnt_ff - 1'b1;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tick_ff <= cnt_zero;
        end
    end

    assign cif.bit_tick = tick_ff;
endmodule // lsed_bit_div

// ===== logic/lsed_chk_unit.sv
// frame checksum accumulator with carry wrap, classic or enhanced
module lsed_chk_unit
(
    input wire logic core_clk,
    input wire logic nrst,
    lsed_core_if.chk_mp cif
);
    logic [7:0] sum_ff;
    logic err_ff;
    wire [8:0] wide_sum = {1'b0, sum_ff} + {1'b0, cif.chk_byte};
    wire [7:0] carry_sum = wide_sum[7:0] + {7'h00, wide_sum[8]};
    // enhanced sum seeds with the protected id, classic starts empty
    wire [7:0] seed = cif.chk_enhanced ? cif.chk_byte : 8'h00;
    wire [7:0] nxt_sum = cif.chk_is_pid ? seed : (cif.chk_is_last ? 8'h00 : carry_sum);
    wire nxt_err = cif.chk_byte_valid && cif.chk_is_last && (carry_sum != lsed_pkg::CHK_GOOD);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sum_ff <= lsed_pkg::BYTE_RST;
            err_ff <= 1'b0;
        end
        else
        begin
            if (cif.chk_byte_valid)
                sum_ff <= nxt_sum;
            err_ff <= nxt_err;
        end
    end

    assign cif.chk_err = err_ff;
endmodule // lsed_chk_unit

// ===== logic/lsed_top.sv
// serial and line-bus receive/transmit error detection
//
// Functional notes
// - received character with bad parity sets the parity flag when parity is on
// - address-bit mode folds the address bit into the parity sum
// - idle-line mode takes parity over data bits only
// - parity error when count of ones disagrees with the parity bit
// - parity enable bit 2 low forces the parity flag to zero
// - parity flag reaches the interrupt only with its enable set
// - new character over an unread one overwrites it and flags overrun when enabled
// - missing stop bit flags framing error when enabled
// - break phase seen high at the bit monitor flags a physical bus error
// - delimiter phase seen low flags a physical bus error
// - response not done within max frame time flags no-response
// - reading the no-response vector offset clears that flag
// - readback differing from driven level while sending flags bit error when enabled
// - wrong received frame checksum sets the checksum flag
// - checksum type picks classic or enhanced summing
// - reading the checksum vector offset clears that flag
// - identifier parity bits checked with mixed even/odd rule when parity on
// - identifier with bad parity is marked invalid
// - line low ten bit periods after missing stop bit is a break
// - break sets receive status bit 5 and interrupts when its enable bit 8 is set
module lsed_top
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic receive_line,
    input wire logic [7:0] global_control_one,
    input wire logic parity_odd,
    input wire logic addr_bit_mode,
    input wire logic checksum_type_select,
    input wire logic [8:0] interrupt_enable_set_reg,
    input wire logic [15:0] bit_divisor,
    input wire logic [9:0] max_frame_time,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_addr_bit,
    input wire logic rx_parity_bit,
    input wire logic rx_stop_fail,
    input wire logic rx_buf_read,
    input wire logic tx_active,
    input wire logic tx_level,
    input wire logic hdr_break_phase,
    input wire logic hdr_delim_phase,
    input wire logic header_done,
    input wire logic response_done,
    input wire logic frame_byte_valid,
    input wire logic [7:0] frame_byte,
    input wire logic frame_byte_is_pid,
    input wire logic frame_byte_is_last,
    input wire logic [8:0] flag_clear,
    input wire logic vector_read,
    output logic [8:0] error_flags,
    output logic parity_error_flag,
    output logic break_detect_flag,
    output logic [7:0] receive_status_reg,
    output logic error_irq,
    output logic [3:0] interrupt_vector_offset_regs,
    output logic [7:0] rx_buffer,
    output logic rx_full,
    output logic id_valid,
    output logic [5:0] id_value
);
    ////////////////////////////////////////////////////////////////////////////////
    // helper units
    lsed_core_if cif ();

    assign cif.div_value = bit_divisor;
    assign cif.chk_byte_valid = frame_byte_valid;
    assign cif.chk_byte = frame_byte;
    assign cif.chk_is_pid = frame_byte_is_pid;
    assign cif.chk_is_last = frame_byte_is_last;
    assign cif.chk_enhanced = checksum_type_select;

    lsed_bit_div u_div
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .cif(cif.div_mp)
    );

    lsed_chk_unit u_chk
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .cif(cif.chk_mp)
    );

    wire tick = cif.bit_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // line synchroniser
    logic rx_meta_ff;
    logic rx_sync_ff;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end
        else
        begin
            rx_meta_ff <= receive_line;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // character checks
    logic rx_full_ff;
    logic [7:0] rx_buf_ff;
    wire parity_en = global_control_one[lsed_pkg::GCR1_PAR_BIT];
    wire addr_term = addr_bit_mode & rx_addr_bit;
    wire ones_odd = (^rx_data) ^ addr_term ^ rx_parity_bit;
    wire par_bad = parity_odd ? ~ones_odd : ones_odd;
    wire set_pe = rx_char_valid & parity_en & par_bad;
    wire set_oe = rx_char_valid & rx_full_ff & interrupt_enable_set_reg[lsed_pkg::F_OE];
    wire set_fe = rx_stop_fail & interrupt_enable_set_reg[lsed_pkg::F_FE];


    // new data always overwrites; a read in the same cycle leaves the new one unread
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_full_ff <= 1'b0;
            rx_buf_ff <= lsed_pkg::BYTE_RST;
        end
        else
        begin
            if (rx_char_valid)
                rx_buf_ff <= rx_data;
            rx_full_ff <= rx_char_valid | (rx_full_ff & ~rx_buf_read);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // identifier parity
    wire pid_p0 = frame_byte[0] ^ frame_byte[1] ^ frame_byte[2] ^ frame_byte[4];
    wire pid_p1 = ~(frame_byte[1] ^ frame_byte[3] ^ frame_byte[4] ^ frame_byte[5]);
    wire pid_bad = (pid_p0 != frame_byte[6]) | (pid_p1 != frame_byte[7]);
    wire pid_take = frame_byte_valid & frame_byte_is_pid;
    wire set_isf = pid_take & parity_en & pid_bad;

    logic id_valid_ff;
    logic [5:0] id_value_ff;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            id_valid_ff <= 1'b0;
            id_value_ff <= 6'h00;
        end
        else if (pid_take)
        begin
            id_valid_ff <= ~set_isf;
            id_value_ff <= frame_byte[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bit monitor during transmission and header
    // driven side delayed two clocks so it lines up with the synchronised readback
    logic [3:0] drv_d1_ff;
    logic [3:0] drv_d2_ff;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            drv_d1_ff <= 4'h0;
            drv_d2_ff <= 4'h0;
        end
        else
        begin
            drv_d1_ff <= {tx_active, tx_level, hdr_break_phase, hdr_delim_phase};
            drv_d2_ff <= drv_d1_ff;
        end
    end

    wire drv_active = drv_d2_ff[3];
    wire drv_level = drv_d2_ff[2];
    wire drv_break = drv_d2_ff[1];
    wire drv_delim = drv_d2_ff[0];
    wire mon_diff = drv_active & tick & (rx_sync_ff != drv_level);
    wire set_be = mon_diff & interrupt_enable_set_reg[lsed_pkg::F_BE];
    wire brk_stuck = drv_break & tick & rx_sync_ff;
    wire dlm_stuck = drv_delim & tick & ~rx_sync_ff;
    wire set_pbe = brk_stuck | dlm_stuck;

    ////////////////////////////////////////////////////////////////////////////////
    // break detection after a missing stop bit
    logic brk_arm_ff;
    logic [3:0] brk_cnt_ff;
    wire brk_last = (brk_cnt_ff == lsed_pkg::BRK_BITS - 4'h1);
    wire set_brk = brk_arm_ff & tick & ~rx_sync_ff & brk_last;
    wire brk_abort = brk_arm_ff & rx_sync_ff;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            brk_arm_ff <= 1'b0;
            brk_cnt_ff <= 4'h0;
        end
        else if (rx_stop_fail)
        begin
            brk_arm_ff <= 1'b1;
            brk_cnt_ff <= 4'h0;
        end
        else if (brk_abort | set_brk)
            brk_arm_ff <= 1'b0;
        else if (brk_arm_ff & tick)
            brk_cnt_ff <= brk_cnt_ff + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // response timeout after a sent header
    logic nre_run_ff;
    logic [lsed_pkg::FRM_W-1:0] frm_cnt_ff;
    wire [lsed_pkg::FRM_W-1:0] frm_inc = frm_cnt_ff + 1'b1;
    wire set_nre = nre_run_ff & ~response_done & tick & (frm_inc >= max_frame_time);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            nre_run_ff <= 1'b0;
            frm_cnt_ff <= '0;
        end
        else if (header_done)
        begin
            nre_run_ff <= 1'b1;
            frm_cnt_ff <= '0;
        end
        else if (response_done | set_nre)
            nre_run_ff <= 1'b0;
        else if (nre_run_ff & tick)
            frm_cnt_ff <= frm_inc;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky flags and interrupt vector
    logic [8:0] flags_ff;
    logic [3:0] vec_ff;
    logic irq_ff;
    logic [3:0] nxt_vec;
    wire [8:0] set_vec = {set_brk, set_isf, cif.chk_err, set_be, set_nre, set_pbe, set_fe, set_oe, set_pe};
    wire [8:0] pend = flags_ff & interrupt_enable_set_reg;
    wire vec_hit = vector_read & (vec_ff != lsed_pkg::VEC_NONE);
    wire [3:0] vec_idx = vec_ff - 4'h1;
    wire [8:0] par_off = {8'h00, ~parity_en};

    always_comb
    begin
        nxt_vec = lsed_pkg::VEC_NONE;
        for (int i = lsed_pkg::NFLAG - 1; i >= 0; i--)
            if (pend[i])
                nxt_vec = 4'(i + 1);
    end

    wire [8:0] nxt_flags;

    genvar g;
    generate
        for (g = 0; g < lsed_pkg::NFLAG; g++)
        begin : g_flag
            wire clr = flag_clear[g] | (vec_hit & (vec_idx == 4'(g))) | par_off[g];
            assign nxt_flags[g] = set_vec[g] | (flags_ff[g] & ~clr);
        end
    endgenerate

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            flags_ff <= lsed_pkg::FLAGS_RST;
        else
            flags_ff <= nxt_flags;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vec_ff <= lsed_pkg::VEC_NONE;
            irq_ff <= 1'b0;
        end
        else
        begin
            vec_ff <= vec_hit ? lsed_pkg::VEC_NONE : nxt_vec;
            irq_ff <= |pend;
        end
    end

    assign error_flags = flags_ff;
    assign parity_error_flag = flags_ff[lsed_pkg::F_PE];
    assign break_detect_flag = flags_ff[lsed_pkg::F_BRK];
    assign receive_status_reg = {2'b00, flags_ff[lsed_pkg::F_BRK], 5'h00};
    assign error_irq = irq_ff;
    assign interrupt_vector_offset_regs = vec_ff;
    assign rx_buffer = rx_buf_ff;
    assign rx_full = rx_full_ff;
    assign id_valid = id_valid_ff;
    assign id_value = id_value_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    parity_off_a: assert property (!parity_en |=> !parity_error_flag) else $error("parity flag set while off");
    parity_set_a: assert property (set_pe |=> parity_error_flag) else $error("parity error missed");
    overrun_set_a: assert property (rx_char_valid && rx_full_ff && interrupt_enable_set_reg[1]
        |=> error_flags[1] && rx_buffer == $past(rx_data)) else $error("overrun missed");
    frame_set_a: assert property (rx_stop_fail && interrupt_enable_set_reg[2] |=> error_flags[2])
        else $error("framing error missed");
    bit_error_a: assert property (drv_active && tick && rx_sync_ff != drv_level
        && interrupt_enable_set_reg[5] |=> error_flags[5])
        else $error("bit error missed");
    bus_error_a: assert property (drv_break && tick && rx_sync_ff |=> error_flags[3])
        else $error("physical bus error missed");
    delim_error_a: assert property (drv_delim && tick && !rx_sync_ff |=> error_flags[3])
        else $error("delimiter bus error missed");
    break_time_a: assert property ($rose(break_detect_flag) |->
        $past(brk_cnt_ff) == 4'h9 && receive_status_reg[5]) else $error("break not after ten bit periods");
    id_bad_a: assert property (set_isf |=> !id_valid && error_flags[7]) else $error("bad id accepted");
    nre_set_a: assert property (set_nre |=> error_flags[4]) else $error("no-response flag missed");
    nre_clear_a: assert property (vector_read && vec_ff == 4'h5 && !set_nre |=> !error_flags[4])
        else $error("no-response flag not cleared");
    chk_set_a: assert property (cif.chk_err |=> error_flags[6]) else $error("checksum flag missed");
    flag_sticky_a: assert property ($fell(error_flags[6]) |-> $past(vector_read) || $past(flag_clear[6]))
        else $error("checksum flag dropped on its own");
    irq_gate_a: assert property (error_irq |-> $past(pend) != 9'h000)
        else $error("interrupt without enabled flag");

    break_seen_c: cover property (set_brk);
    nre_seen_c: cover property (set_nre ##[1:20] vector_read);
    chk_seen_c: cover property (cif.chk_err && checksum_type_select);
    overrun_seen_c: cover property (set_oe);
    bit_error_seen_c: cover property (set_be);
endmodule // lsed_top

// ===== bench/lsed_bus_node.sv
// far-side node model on the single-wire bus
module lsed_bus_node
(
    input wire logic tx_active,
    input wire logic tx_level,
    input wire logic [1:0] bus_mode,
    output logic bus_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // 0 wired-and with pull-up, 1 shorted high, 2 shorted or held low
    always_comb
    begin
        case (bus_mode)
            2'h1: bus_line = 1'b1;
            2'h2: bus_line = 1'b0;
            default: bus_line = tx_active ? tx_level : 1'b1;
        endcase
    end
endmodule // lsed_bus_node

// ===== bench/lsed_top_test.sv
// self-checking bench for the serial error detection block
module lsed_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, nrst = 1'b0, parity_odd = 1'b0, addr_bit_mode = 1'b0, checksum_type_select = 1'b0;
    logic rx_char_valid = 1'b0, rx_addr_bit = 1'b0, rx_parity_bit = 1'b0, rx_stop_fail = 1'b0, rx_buf_read = 1'b0;
    logic tx_active = 1'b0, tx_level = 1'b1, hdr_break_phase = 1'b0, hdr_delim_phase = 1'b0, header_done = 1'b0;
    logic response_done = 1'b0, frame_byte_valid = 1'b0, frame_byte_is_pid = 1'b0, frame_byte_is_last = 1'b0;
    logic vector_read = 1'b0, bus_line, error_irq, rx_full, id_valid, parity_error_flag, break_detect_flag, pe, ct;
    logic [7:0] global_control_one = 8'h00, rx_data = 8'h00, frame_byte = 8'h00, receive_status_reg, rx_buffer;
    logic [8:0] interrupt_enable_set_reg = 9'h000, flag_clear = 9'h000, error_flags;
    logic [3:0] interrupt_vector_offset_regs;
    logic [5:0] id_value, id;
    logic [1:0] bus_mode = 2'h0, flt;
    logic [7:0] pid, s, b;
    logic [14:0] bm [6] = '{15'h1200, 15'h3008, 15'h4C08, 15'h4620, 15'h4400, 15'h0600};
    int err_count = 0, tests_run = 0, cycles = 0;

    lsed_bus_node lsed_bus_node_i (.tx_active, .tx_level, .bus_mode, .bus_line);
    lsed_top lsed_top_i (.core_clk, .nrst, .receive_line(bus_line), .global_control_one, .parity_odd,
        .addr_bit_mode, .checksum_type_select, .interrupt_enable_set_reg, .bit_divisor(16'h0003),
        .max_frame_time(10'h00A), .rx_char_valid, .rx_data, .rx_addr_bit, .rx_parity_bit, .rx_stop_fail,
        .rx_buf_read, .tx_active, .tx_level, .hdr_break_phase, .hdr_delim_phase, .header_done, .response_done,
        .frame_byte_valid, .frame_byte, .frame_byte_is_pid, .frame_byte_is_last, .flag_clear, .vector_read,
        .error_flags, .parity_error_flag, .break_detect_flag, .receive_status_reg, .error_irq,
        .interrupt_vector_offset_regs, .rx_buffer, .rx_full, .id_valid, .id_value);

    always #20 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic clr;
        flag_clear <= 9'h1FF;
        cyc(1);
        flag_clear <= 9'h000;
        cyc(3);
    endtask

    task automatic vread;
        vector_read <= 1'b1;
        cyc(1);
        vector_read <= 1'b0;
        cyc(2);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic par_bit(input logic [7:0] d, input logic a);
        return ^d ^ (addr_bit_mode & a) ^ parity_odd;
    endfunction

    function automatic logic [7:0] pid_of(input logic [5:0] i);
        return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
    endfunction

    // eight-bit add with the carry folded back in
    function automatic logic [7:0] wsum(input logic [7:0] a, input logic [7:0] c);
        logic [8:0] t;
        t = a + c;
        return t[7:0] + 8'(t[8]);
    endfunction

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(21893));
        cyc(10);
        nrst <= 1'b1;
        cyc(2);
        chk("reset flags", error_flags, 9'h000);
        repeat (24)
        begin
            {global_control_one[2], parity_odd, addr_bit_mode, rx_addr_bit, rx_parity_bit,
                interrupt_enable_set_reg[0]} <= 6'($urandom);
            rx_data <= 8'($urandom);
            rx_char_valid <= 1'b1;
            cyc(1);
            rx_char_valid <= 1'b0;
            rx_buf_read <= 1'b1;
            cyc(1);
            rx_buf_read <= 1'b0;
            cyc(3);
            pe = global_control_one[2] & (rx_parity_bit != par_bit(rx_data, rx_addr_bit));
            chk("parity flags", error_flags, {8'h00, pe});
            chk("parity pin", parity_error_flag, pe);
            chk("parity irq", error_irq, pe & interrupt_enable_set_reg[0]);
            chk("rx buffer", rx_buffer, rx_data);
            chk("rx empty", rx_full, 1'b0);
            clr();
        end
        $display("done: data parity");
        global_control_one <= 8'h00;
        for (int en = 0; en < 2; en++)
        begin
            interrupt_enable_set_reg <= 9'(en * 6);
            rx_data <= 8'h5A;
            rx_char_valid <= 1'b1;
            rx_stop_fail <= 1'b1;
            cyc(1);
            rx_stop_fail <= 1'b0;
            rx_data <= 8'hA5;
            cyc(1);
            rx_char_valid <= 1'b0;
            cyc(4);
            chk("overrun framing", error_flags, 9'(en * 6));
            chk("overwritten", rx_buffer, 8'hA5);
            chk("rx full", rx_full, 1'b1);
            chk("or fe vector", interrupt_vector_offset_regs, 9'(en * 2));
            rx_buf_read <= 1'b1;
            cyc(1);
            rx_buf_read <= 1'b0;
            clr();
        end
        $display("done: overrun and framing");
        interrupt_enable_set_reg <= 9'h000;
        for (int i = 0; i < 6; i++)
        begin
            {bus_mode, tx_level, interrupt_enable_set_reg[5]} <= {bm[i][14:13], bm[i][10:9]};
            cyc(4);
            {hdr_break_phase, hdr_delim_phase, tx_active} <= {bm[i][12:11], 1'b1};
            cyc(20);
            {hdr_break_phase, hdr_delim_phase, tx_active, bus_mode} <= 5'h00;
            cyc(4);
            chk("bit monitor", error_flags, bm[i][8:0]);
            clr();
        end
        $display("done: bit monitor");
        interrupt_enable_set_reg <= 9'h100;
        for (int ab = 0; ab < 2; ab++)
        begin
            bus_mode <= 2'h2;
            cyc(4);
            rx_stop_fail <= 1'b1;
            cyc(1);
            rx_stop_fail <= 1'b0;
            cyc(16);
            if (ab == 1)
                bus_mode <= 2'h0;
            cyc(12);
            chk("break early", error_flags, 9'h000);
            cyc(30);
            chk("break flags", error_flags, 9'(ab ? 0 : 256));
            chk("break pin", break_detect_flag, 1'(ab == 0));
            chk("rx status", receive_status_reg, ab ? 9'h000 : 9'h020);
            chk("break irq", error_irq, 1'(ab == 0));
            bus_mode <= 2'h0;
            cyc(4);
            clr();
        end
        $display("done: break");
        interrupt_enable_set_reg <= 9'h010;
        for (int rd = 0; rd < 2; rd++)
        begin
            header_done <= 1'b1;
            cyc(1);
            header_done <= 1'b0;
            cyc(20);
            response_done <= 1'(rd);
            cyc(1);
            response_done <= 1'b0;
            cyc(4);
            chk("no response early", error_flags, 9'h000);
            cyc(30);
            chk("no response", error_flags, 9'(rd ? 0 : 16));
            chk("nre vector", interrupt_vector_offset_regs, 9'(rd ? 0 : 5));
            vread();
            chk("nre cleared", error_flags, 9'h000);
            clr();
        end
        $display("done: no response");
        global_control_one <= 8'h04;
        interrupt_enable_set_reg <= 9'h0C0;
        repeat (16)
        begin
            id = 6'($urandom);
            flt = 2'($urandom);
            ct = 1'($urandom);
            pid = pid_of(id) ^ {flt[0], 7'h00};
            s = ct ? pid : 8'h00;
            checksum_type_select <= ct;
            {frame_byte_valid, frame_byte_is_pid, frame_byte} <= {2'h3, pid};
            cyc(1);
            frame_byte_is_pid <= 1'b0;
            repeat (1 + $urandom % 4)
            begin
                b = 8'($urandom);
                s = wsum(s, b);
                frame_byte <= b;
                cyc(1);
            end
            {frame_byte_is_last, frame_byte} <= {1'b1, ~s ^ {7'h00, flt[1]}};
            cyc(1);
            {frame_byte_valid, frame_byte_is_last} <= 2'h0;
            cyc(4);
            chk("frame flags", error_flags, {1'b0, flt[0], flt[1], 6'h00});
            chk("id valid", id_valid, !flt[0]);
            if (!flt[0])
                chk("id value", id_value, id);
            if (flt[1])
            begin
                chk("ce vector", interrupt_vector_offset_regs, 9'h007);
                vread();
                chk("ce cleared", error_flags[6], 1'b0);
            end
            clr();
        end
        $display("done: frame checks");
        summarize();
    end
endmodule // lsed_top_test
